// File: include/uart_pkg.sv
package uart_pkg;
   // ==========================================================
   // register indices (byte address is four times the index)
   localparam logic [5:0] IDX_BAUD_HI = 6'h03;
   localparam logic [5:0] IDX_BAUD_LO = 6'h09;
   localparam logic [5:0] IDX_CTRL    = 6'h0a;
   localparam logic [5:0] IDX_FLAGS   = 6'h0b;
   localparam logic [5:0] IDX_DATA    = 6'h0c;
   localparam int         ADDR_W      = 8;
   localparam int         DIV_W_DEF   = 12;
   // ==========================================================
   // serial_ctrl_enables fields
   localparam int C_RXIE  = 7;
   localparam int C_TX_DONE_IE = 6;
   localparam int C_TX_EMPTY_IE = 5;
   localparam int C_RXON  = 4;
   localparam int C_TXON  = 3;
   localparam int C_NINE  = 2;
   localparam int C_RX9   = 1;
   localparam int C_TX9   = 0;
   localparam logic [7:0] CTRL_RST = 8'h02;
   // ==========================================================
   // serial_flags_status fields
   localparam int F_RXC  = 7;
   localparam int F_TXC  = 6;
   localparam int F_MULTIPROC_MODE = 0;
   // ==========================================================
   // serial timing
   localparam logic [3:0] SMP_V1   = 4'h8;
   localparam logic [3:0] SMP_V2   = 4'h9;
   localparam logic [3:0] SMP_V3   = 4'ha;
   localparam logic [3:0] SMP_LAST = 4'hf;
   localparam logic [3:0] BITS8    = 4'ha;
   localparam logic [3:0] BITS9    = 4'hb;
   localparam logic [3:0] STOP8    = 4'h9;
   localparam logic [3:0] STOP9    = 4'ha;
   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   // ==========================================================
   // state types
   typedef enum logic {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} tx_state_t;
   typedef enum logic {RX_IDLE = 1'b0, RX_BUSY = 1'b1} rx_state_t;
endpackage : uart_pkg

// File: logic/uart_core.sv
// Overview of operation
// - tx_done set after stop bit, nothing pending
// - tx_done cleared by vector ack or one-write
// - tx_done interrupt when enabled and global on
// - tx_buf_empty set on holding-to-shifter move
// - empty interrupt is level while flag set
// - data register write clears tx_buf_empty
// - tx_buf_empty is one during reset
// - frame_err set by a low received stop bit, cleared by a high one
// - overrun shows after buffered character read
// - overrun cleared on successful receive transfer
// - flag bits two and one read zero
// - multiproc_mode drops non-address characters
// - rx_done interrupt when enabled and global on
// - receiver off sets no receive flags
// - tx_on clear drains pending characters first
// - nine_bit_char gives nine data bits
// - ninth received bit readable, resets one
// - tx_ninth_bit sent as ninth bit
// - baud is clock over sixteen times divisor+1
// - DIV_W-bit divisor (twelve by default) from high and low
// - sixteen samples, majority of eight-nine-ten
// - low start, data lsb first, high stop
// - reading receive data clears rx_done
// - data address splits write and read
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps
module uart_core #(
   parameter int DIV_W = uart_pkg::DIV_W_DEF
) (
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   input  wire logic [uart_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                       awvalid,
   output logic                            awready,
   input  wire logic [31:0]                wdata,
   input  wire logic [3:0]                 wstrb,
   input  wire logic                       wvalid,
   output logic                            wready,
   output logic [1:0]                      bresp,
   output logic                            bvalid,
   input  wire logic                       bready,
   input  wire logic [uart_pkg::ADDR_W-1:0] araddr,
   input  wire logic                       arvalid,
   output logic                            arready,
   output logic [31:0]                     rdata,
   output logic [1:0]                      rresp,
   output logic                            rvalid,
   input  wire logic                       rready,
   input  wire logic                       rxd,
   output logic                            txd,
   input  wire logic                       global_ie,
   input  wire logic                       tx_done_ack,
   output logic                            irq_rx_done,
   output logic                            irq_tx_done,
   output logic                            irq_tx_empty
);
   if (DIV_W < 9 || DIV_W > 12) begin : g_bad_div
      $error("DIV_W must lie in 9..12");
   end

   function automatic logic maj3(input logic a, b, c);
      maj3 = (a & b) | (a & c) | (b & c);
   endfunction : maj3

   function automatic logic [5:0] widx(input logic [7:0] a);
      widx = a[7:2];
   endfunction : widx

   // ==========================================================
   // bus slave state
   logic [7:0]  aw_addr_r, aw_addr_nxt;
   logic [7:0]  w_data_r, w_data_nxt;
   logic        w_strb_r, w_strb_nxt;
   logic        aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
   logic        awready_r, awready_nxt, wready_r, wready_nxt;
   logic        bvalid_r, bvalid_nxt, arready_r, arready_nxt;
   logic        rvalid_r, rvalid_nxt;
   logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic        wr_go, rd_go, wr_data, rx_read;
   logic [5:0]  rd_i;
   // ==========================================================
   // register state
   logic [7:0]       ctrl_r, ctrl_nxt, hold_r, hold_nxt;
   logic [7:0]       rx_data_r, rx_data_nxt;
   logic [7:0]       div_lo_r, div_lo_nxt;
   logic [DIV_W-9:0] div_hi_r, div_hi_nxt;
   logic [DIV_W-1:0] divisor;
   logic rxc_r, rxc_nxt, txc_r, txc_nxt, empty_r, empty_nxt;
   logic fe_r, fe_nxt, ovr_r, ovr_nxt, ovr_pend_r, ovr_pend_nxt;
   logic multiproc_mode_r, multiproc_mode_nxt;
   logic irq_rx_r, irq_rx_nxt, irq_txc_r, irq_txc_nxt;
   logic irq_emp_r, irq_emp_nxt;
   logic keep;
   // ==========================================================
   // baud and transmitter state
   logic [DIV_W-1:0] baud_cnt_r, baud_cnt_nxt;
   logic [3:0]       tx_sub_r, tx_sub_nxt, tx_left_r, tx_left_nxt;
   logic [10:0]      tx_sh_r, tx_sh_nxt;
   uart_pkg::tx_state_t tx_state_r, tx_state_nxt;
   logic             txd_r, txd_nxt, baud_tick, bit_tick;
   logic             tx_load, txc_set;
   // ==========================================================
   // receiver state
   uart_pkg::rx_state_t rx_state_r, rx_state_nxt;
   logic [3:0]      smp_r, smp_nxt, bidx_r, bidx_nxt;
   logic [8:0]      rsh_r, rsh_nxt;
   logic [1:0]      vote_r, vote_nxt;
   logic            rxd_s1_r, rxd_s2_r;
   logic            rx_end, rx_stop, rx_bit;

   // ==========================================================
   // axi4-lite slave
   assign wr_go   = aw_have_r & w_have_r & ~bvalid_r;
   assign rd_go   = arvalid & arready_r;
   assign rd_i    = widx(araddr);
   assign wr_data = wr_go & w_strb_r
                    & (widx(aw_addr_r) == uart_pkg::IDX_DATA);
   assign rx_read = rd_go & (rd_i == uart_pkg::IDX_DATA);

   always_comb begin
      aw_addr_nxt = aw_addr_r;
      w_data_nxt  = w_data_r;
      w_strb_nxt  = w_strb_r;
      aw_have_nxt = aw_have_r;
      w_have_nxt  = w_have_r;
      bvalid_nxt  = bvalid_r;
      bresp_nxt   = bresp_r;
      rvalid_nxt  = rvalid_r;
      rresp_nxt   = rresp_r;
      rdata_nxt   = rdata_r;
      if (awvalid && awready_r) begin
         aw_addr_nxt = awaddr;
         aw_have_nxt = 1'b1;
      end
      if (wvalid && wready_r) begin
         w_data_nxt = wdata[7:0];
         w_strb_nxt = wstrb[0];
         w_have_nxt = 1'b1;
      end
      if (bvalid_r && bready)
         bvalid_nxt = 1'b0;
      if (wr_go) begin
         aw_have_nxt = 1'b0;
         w_have_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         case (widx(aw_addr_r))
            uart_pkg::IDX_BAUD_HI, uart_pkg::IDX_BAUD_LO,
            uart_pkg::IDX_CTRL, uart_pkg::IDX_FLAGS,
            uart_pkg::IDX_DATA: bresp_nxt = uart_pkg::RESP_OK;
            default: bresp_nxt = uart_pkg::RESP_ERR;
         endcase
      end
      if (rvalid_r && rready)
         rvalid_nxt = 1'b0;
      if (rd_go) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = uart_pkg::RESP_OK;
         rdata_nxt  = 32'h0;
         case (rd_i)
            uart_pkg::IDX_BAUD_HI: rdata_nxt[DIV_W-9:0] = div_hi_r;
            uart_pkg::IDX_BAUD_LO: rdata_nxt[7:0] = div_lo_r;
            uart_pkg::IDX_CTRL:
               rdata_nxt[7:0] = {ctrl_r[7:1], 1'b0};
            uart_pkg::IDX_FLAGS:
               rdata_nxt[7:0] = {rxc_r, txc_r, empty_r, fe_r,
                                 ovr_r, 2'b00, multiproc_mode_r};
            uart_pkg::IDX_DATA: rdata_nxt[7:0] = rx_data_r;
            default: rresp_nxt = uart_pkg::RESP_ERR;
         endcase
      end
      awready_nxt = ~aw_have_nxt & ~bvalid_nxt;
      wready_nxt  = ~w_have_nxt & ~bvalid_nxt;
      arready_nxt = ~rvalid_nxt;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_addr_r <= 8'h00;
         w_data_r  <= 8'h00;
         w_strb_r  <= 1'b0;
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= uart_pkg::RESP_OK;
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rresp_r   <= uart_pkg::RESP_OK;
         rdata_r   <= 32'h0;
      end else begin
         aw_addr_r <= aw_addr_nxt;
         w_data_r  <= w_data_nxt;
         w_strb_r  <= w_strb_nxt;
         aw_have_r <= aw_have_nxt;
         w_have_r  <= w_have_nxt;
         awready_r <= awready_nxt;
         wready_r  <= wready_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
         arready_r <= arready_nxt;
         rvalid_r  <= rvalid_nxt;
         rresp_r   <= rresp_nxt;
         rdata_r   <= rdata_nxt;
      end
   end

   // ==========================================================
   // baud divider and transmitter
   assign divisor   = {div_hi_r, div_lo_r};
   assign baud_tick = (baud_cnt_r == '0);
   assign bit_tick  = baud_tick & (tx_sub_r == uart_pkg::SMP_LAST);

   always_comb begin
      baud_cnt_nxt = baud_tick ? divisor : baud_cnt_r - 1'b1;
      tx_sub_nxt   = baud_tick ? tx_sub_r + 4'h1 : tx_sub_r;
      tx_state_nxt = tx_state_r;
      tx_sh_nxt    = tx_sh_r;
      tx_left_nxt  = tx_left_r;
      txd_nxt      = txd_r;
      tx_load      = 1'b0;
      txc_set      = 1'b0;
      case (tx_state_r)
         uart_pkg::TX_IDLE: begin
            txd_nxt = 1'b1;
            tx_load = ~empty_r & ~wr_data & ctrl_r[uart_pkg::C_TXON];
         end
         uart_pkg::TX_SHIFT: begin
            if (bit_tick) begin
               if (tx_left_r != 4'h0) begin
                  txd_nxt     = tx_sh_r[0];
                  tx_sh_nxt   = {1'b1, tx_sh_r[10:1]};
                  tx_left_nxt = tx_left_r - 4'h1;
               end else if (!empty_r) begin
                  tx_load = ~wr_data;
               end else begin
                  txc_set      = 1'b1;
                  tx_state_nxt = uart_pkg::TX_IDLE;
               end
            end
         end
         default: tx_state_nxt = uart_pkg::TX_IDLE;
      endcase
      if (tx_load) begin
         tx_state_nxt = uart_pkg::TX_SHIFT;
         if (ctrl_r[uart_pkg::C_NINE]) begin
            tx_sh_nxt   = {1'b1, ctrl_r[uart_pkg::C_TX9],
                           hold_r, 1'b0};
            tx_left_nxt = uart_pkg::BITS9;
         end else begin
            tx_sh_nxt   = {2'b11, hold_r, 1'b0};
            tx_left_nxt = uart_pkg::BITS8;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         baud_cnt_r <= '0;
         tx_sub_r   <= 4'h0;
         tx_state_r <= uart_pkg::TX_IDLE;
         tx_sh_r    <= 11'h7ff;
         tx_left_r  <= 4'h0;
         txd_r      <= 1'b1;
      end else begin
         baud_cnt_r <= baud_cnt_nxt;
         tx_sub_r   <= tx_sub_nxt;
         tx_state_r <= tx_state_nxt;
         tx_sh_r    <= tx_sh_nxt;
         tx_left_r  <= tx_left_nxt;
         txd_r      <= txd_nxt;
      end
   end

   // ==========================================================
   // receiver
   always_comb begin
      rx_state_nxt = rx_state_r;
      smp_nxt      = smp_r;
      bidx_nxt     = bidx_r;
      rsh_nxt      = rsh_r;
      vote_nxt     = vote_r;
      rx_end       = 1'b0;
      rx_bit       = maj3(vote_r[1], vote_r[0], rxd_s2_r);
      rx_stop      = rx_bit;
      case (rx_state_r)
         uart_pkg::RX_IDLE: begin
            if (baud_tick && !rxd_s2_r) begin
               rx_state_nxt = uart_pkg::RX_BUSY;
               smp_nxt      = 4'h1;
               bidx_nxt     = 4'h0;
            end
         end
         uart_pkg::RX_BUSY: begin
            if (baud_tick) begin
               smp_nxt = smp_r + 4'h1;
               if (smp_r == uart_pkg::SMP_V1)
                  vote_nxt[0] = rxd_s2_r;
               if (smp_r == uart_pkg::SMP_V2)
                  vote_nxt[1] = rxd_s2_r;
               if (smp_r == uart_pkg::SMP_V3) begin
                  if (bidx_r == 4'h0 && rx_bit)
                     rx_state_nxt = uart_pkg::RX_IDLE;
                  else if (bidx_r == (ctrl_r[uart_pkg::C_NINE] ?
                           uart_pkg::STOP9 : uart_pkg::STOP8)) begin
                     rx_end       = 1'b1;
                     rx_state_nxt = uart_pkg::RX_IDLE;
                  end else if (bidx_r != 4'h0)
                     rsh_nxt = {rx_bit, rsh_r[8:1]};
               end
               if (smp_r == uart_pkg::SMP_LAST)
                  bidx_nxt = bidx_r + 4'h1;
            end
         end
         default: rx_state_nxt = uart_pkg::RX_IDLE;
      endcase
      if (!ctrl_r[uart_pkg::C_RXON]) begin
         rx_state_nxt = uart_pkg::RX_IDLE;
         rx_end       = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rxd_s1_r   <= 1'b1;
         rxd_s2_r   <= 1'b1;
         rx_state_r <= uart_pkg::RX_IDLE;
         smp_r      <= 4'h0;
         bidx_r     <= 4'h0;
         rsh_r      <= 9'h000;
         vote_r     <= 2'b11;
      end else begin
         rxd_s1_r   <= rxd;
         rxd_s2_r   <= rxd_s1_r;
         rx_state_r <= rx_state_nxt;
         smp_r      <= smp_nxt;
         bidx_r     <= bidx_nxt;
         rsh_r      <= rsh_nxt;
         vote_r     <= vote_nxt;
      end
   end

   // ==========================================================
   // control, status and data registers
   assign keep = ~multiproc_mode_r | (ctrl_r[uart_pkg::C_NINE] ?
                 rsh_r[8] : rx_stop);

   always_comb begin
      ctrl_nxt     = ctrl_r;
      hold_nxt     = hold_r;
      rx_data_nxt  = rx_data_r;
      div_lo_nxt   = div_lo_r;
      div_hi_nxt   = div_hi_r;
      rxc_nxt      = rxc_r;
      txc_nxt      = txc_r;
      empty_nxt    = empty_r;
      fe_nxt       = fe_r;
      ovr_nxt      = ovr_r;
      ovr_pend_nxt = ovr_pend_r;
      multiproc_mode_nxt     = multiproc_mode_r;
      if (rx_read) begin
         rxc_nxt      = 1'b0;
         ovr_nxt      = ovr_pend_r;
         ovr_pend_nxt = 1'b0;
      end
      if (tx_done_ack)
         txc_nxt = 1'b0;
      if (wr_go && w_strb_r) begin
         case (widx(aw_addr_r))
            uart_pkg::IDX_CTRL:
               ctrl_nxt = {w_data_r[7:2], ctrl_r[uart_pkg::C_RX9],
                           w_data_r[0]};
            uart_pkg::IDX_FLAGS: begin
               if (w_data_r[uart_pkg::F_TXC])
                  txc_nxt = 1'b0;
               multiproc_mode_nxt = w_data_r[uart_pkg::F_MULTIPROC_MODE];
            end
            uart_pkg::IDX_BAUD_HI: div_hi_nxt = w_data_r[DIV_W-9:0];
            uart_pkg::IDX_BAUD_LO: div_lo_nxt = w_data_r;
            uart_pkg::IDX_DATA: begin
               hold_nxt  = w_data_r;
               empty_nxt = 1'b0;
            end
            default: ;
         endcase
      end
      if (tx_load)
         empty_nxt = 1'b1;
      if (txc_set)
         txc_nxt = 1'b1;
      if (rx_end && keep) begin
         if (rxc_r && !rx_read)
            ovr_pend_nxt = 1'b1;
         else begin
            rxc_nxt = 1'b1;
            fe_nxt  = ~rx_stop;
            ovr_nxt = ovr_nxt & rx_read;
            if (ctrl_r[uart_pkg::C_NINE]) begin
               rx_data_nxt              = rsh_r[7:0];
               ctrl_nxt[uart_pkg::C_RX9] = rsh_r[8];
            end else
               rx_data_nxt = rsh_r[8:1];
         end
      end
      irq_rx_nxt  = rxc_r & ctrl_r[uart_pkg::C_RXIE]
                    & global_ie;
      irq_txc_nxt = txc_r & ctrl_r[uart_pkg::C_TX_DONE_IE]
                    & global_ie;
      irq_emp_nxt = empty_r & ctrl_r[uart_pkg::C_TX_EMPTY_IE]
                    & global_ie;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r     <= uart_pkg::CTRL_RST;
         hold_r     <= 8'h00;
         rx_data_r  <= 8'h00;
         div_lo_r   <= 8'h00;
         div_hi_r   <= '0;
         rxc_r      <= 1'b0;
         txc_r      <= 1'b0;
         empty_r    <= 1'b1;
         fe_r       <= 1'b0;
         ovr_r      <= 1'b0;
         ovr_pend_r <= 1'b0;
         multiproc_mode_r     <= 1'b0;
         irq_rx_r   <= 1'b0;
         irq_txc_r  <= 1'b0;
         irq_emp_r  <= 1'b0;
      end else begin
         ctrl_r     <= ctrl_nxt;
         hold_r     <= hold_nxt;
         rx_data_r  <= rx_data_nxt;
         div_lo_r   <= div_lo_nxt;
         div_hi_r   <= div_hi_nxt;
         rxc_r      <= rxc_nxt;
         txc_r      <= txc_nxt;
         empty_r    <= empty_nxt;
         fe_r       <= fe_nxt;
         ovr_r      <= ovr_nxt;
         ovr_pend_r <= ovr_pend_nxt;
         multiproc_mode_r     <= multiproc_mode_nxt;
         irq_rx_r   <= irq_rx_nxt;
         irq_txc_r  <= irq_txc_nxt;
         irq_emp_r  <= irq_emp_nxt;
      end
   end

   assign awready      = awready_r;
   assign wready       = wready_r;
   assign bvalid       = bvalid_r;
   assign bresp        = bresp_r;
   assign arready      = arready_r;
   assign rvalid       = rvalid_r;
   assign rresp        = rresp_r;
   assign rdata        = rdata_r;
   assign txd          = txd_r;
   assign irq_rx_done  = irq_rx_r;
   assign irq_tx_done  = irq_txc_r;
   assign irq_tx_empty = irq_emp_r;

   // ==========================================================
   // checks
   property p_empty_reset;
      @(posedge aclk) !aresetn |=> empty_r;
   endproperty
   a_empty_reset: assert property (p_empty_reset)
      else $error("empty flag not set by reset");

   property p_write_clears;
      @(posedge aclk) disable iff (!aresetn)
      wr_data |=> !empty_r ##1 (empty_r == $past(tx_load));
   endproperty
   a_write_clears: assert property (p_write_clears)
      else $error("data write did not clear empty flag");

   property p_idle_high;
      @(posedge aclk) disable iff (!aresetn)
      (tx_state_r == uart_pkg::TX_IDLE) |-> txd_r;
   endproperty
   a_idle_high: assert property (p_idle_high)
      else $error("transmit line low while idle");

   property p_rx_off;
      @(posedge aclk) disable iff (!aresetn)
      $rose(rxc_r) |-> $past(ctrl_r[uart_pkg::C_RXON]);
   endproperty
   a_rx_off: assert property (p_rx_off)
      else $error("receive flag set while receiver off");

   property p_rx_read;
      @(posedge aclk) disable iff (!aresetn)
      (rx_read && !rx_end) |=> !rxc_r;
   endproperty
   a_rx_read: assert property (p_rx_read)
      else $error("data read did not clear rx_done");

   property p_empty_irq;
      @(posedge aclk) disable iff (!aresetn)
      (empty_r && ctrl_r[uart_pkg::C_TX_EMPTY_IE] && global_ie)[*2]
      |-> irq_tx_empty;
   endproperty
   a_empty_irq: assert property (p_empty_irq)
      else $error("empty request not held as a level");

   property p_baud_one;
      @(posedge aclk) disable iff (!aresetn)
      (baud_tick && divisor == 12'h001 && $stable(divisor))
      |=> !baud_tick ##1 baud_tick;
   endproperty
   a_baud_one: assert property (p_baud_one)
      else $error("divisor one gives wrong tick spacing");

   property p_reserved;
      @(posedge aclk) disable iff (!aresetn)
      (rd_go && rd_i == uart_pkg::IDX_FLAGS) |=> rdata[2:1] == 2'b00;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved flag bits read nonzero");

   property p_txc_set;
      @(posedge aclk) disable iff (!aresetn)
      txc_set |=> txc_r && tx_state_r == uart_pkg::TX_IDLE;
   endproperty
   a_txc_set: assert property (p_txc_set)
      else $error("tx_done not set at end of frame");
endmodule : uart_core

// File: tb/far_uart.sv
`timescale 1ns/10ps
// ==========================================
// remote serial end
module far_uart #(
   parameter int BITC = 32
) (
   input  wire logic aclk,
   input  wire logic txd,
   output logic      rxd
);
   initial rxd = 1'b1;
   task automatic send(input logic [7:0] d, input logic stp);
      logic [9:0] f;
      f = {stp, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd <= f[i];
         repeat (BITC) @(posedge aclk);
      end
      rxd <= 1'b1;
      repeat (BITC) @(posedge aclk);
   endtask : send
   task automatic get(output logic [7:0] d);
      @(negedge txd);
      repeat (BITC / 2) @(posedge aclk);
      for (int i = 0; i < 8; i++) begin
         repeat (BITC) @(posedge aclk);
         d[i] = txd;
      end
   endtask : get
endmodule : far_uart

// File: tb/tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
$display("mismatch %0t got %h exp %h", $time, g, e); end end
// ==========================================
// bench top
module tb;
   localparam logic [7:0] DIV = 8'h01;
   localparam logic [7:0] A_HI = {uart_pkg::IDX_BAUD_HI, 2'h0};
   localparam logic [7:0] A_LO = {uart_pkg::IDX_BAUD_LO, 2'h0};
   localparam logic [7:0] A_CT = {uart_pkg::IDX_CTRL, 2'h0};
   localparam logic [7:0] A_FL = {uart_pkg::IDX_FLAGS, 2'h0};
   localparam logic [7:0] A_DT = {uart_pkg::IDX_DATA, 2'h0};
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, rxd, txd;
   logic global_ie, tx_done_ack, irq_rx_done, irq_tx_done, irq_tx_empty;
   logic [7:0]  awaddr, araddr, d, c, q;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   int          miscompares, n_checks;
   uart_core #(.DIV_W(12)) uart_core_inst (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .rxd(rxd), .txd(txd), .global_ie(global_ie),
      .tx_done_ack(tx_done_ack), .irq_rx_done(irq_rx_done),
      .irq_tx_done(irq_tx_done), .irq_tx_empty(irq_tx_empty));
   far_uart #(.BITC(16 * (DIV + 1))) far_uart_inst (.aclk(aclk),
      .txd(txd), .rxd(rxd));
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   task wr(input logic [7:0] a, input logic [7:0] v);
      awaddr <= a; wdata <= {24'h0, v}; awvalid <= 1'b1; wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while ((awvalid && !awready) || (wvalid && !wready));
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      q = rdata[7:0]; r = rresp; rready <= 1'b0;
   endtask : rd
   task print_verdict;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (40000) @(posedge aclk);
      miscompares++;
      print_verdict;
   end
   initial begin
      aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
      arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00;
      wdata = 32'h0; wstrb = 4'hf; global_ie = 1'b1; tx_done_ack = 1'b0;
      d = 8'($urandom(32'h2b13));
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(A_CT); `CHK(q, uart_pkg::CTRL_RST)
      rd(A_FL); `CHK(q, 8'h20)
      rd(8'h00); `CHK(r, uart_pkg::RESP_ERR)
      wr(A_LO, DIV);
      wr(A_HI, 8'h00);
      wr(A_CT, 8'hf8);
      repeat (3) @(posedge aclk);
      `CHK(irq_tx_empty, 1'b1)
      for (int k = 0; k < 3; k++) begin
         d = (k == 0) ? 8'hff : 8'($urandom);
         fork wr(A_DT, d); far_uart_inst.get(c); join
         `CHK(c, d)
         repeat (100) @(posedge aclk);
         `CHK(irq_tx_done, 1'b1)
         rd(A_FL); `CHK(q[6], 1'b1)
         if (k == 1) begin
            tx_done_ack <= 1'b1;
            @(posedge aclk);
            tx_done_ack <= 1'b0;
         end else
            wr(A_FL, 8'h40);
         rd(A_FL); `CHK(q[6], 1'b0)
         `CHK(irq_tx_done, 1'b0)
         d = 8'($urandom);
         far_uart_inst.send(d, 1'b1);
         `CHK(irq_rx_done, 1'b1)
         rd(A_DT); `CHK(q, d)
         rd(A_FL); `CHK(q[7], 1'b0)
      end
      far_uart_inst.send(8'h5a, 1'b0);
      rd(A_FL); `CHK(q[4], 1'b1)
      rd(A_DT);
      far_uart_inst.send(8'h11, 1'b1);
      far_uart_inst.send(8'h22, 1'b1);
      rd(A_FL); `CHK(q[4], 1'b0)
      rd(A_DT); `CHK(q, 8'h11)
      rd(A_FL); `CHK(q[3], 1'b1)
      far_uart_inst.send(8'h33, 1'b1);
      rd(A_FL); `CHK(q[3], 1'b0)
      rd(A_DT);
      wr(A_FL, 8'h01);
      far_uart_inst.send(8'h55, 1'b0);
      rd(A_FL); `CHK(q[7], 1'b0)
      far_uart_inst.send(8'h66, 1'b1);
      rd(A_DT); `CHK(q, 8'h66)
      wr(A_FL, 8'h00);
      wr(A_CT, 8'h08);
      far_uart_inst.send(8'h44, 1'b1);
      rd(A_FL); `CHK(q[7], 1'b0)
      print_verdict;
   end
endmodule : tb
